// ---- logic/ppc_cmd.v ----
// primary command register with its claim, master and parity gating
// Summary of operation
// - I/O enable clear: never claim primary I/O; set: I/O claims allowed.
// - memory enable clear: ignore primary memory cycles; set: memory claims allowed.
// - master enable clear: no secondary claims, no primary mastering; config forwarding unaffected.
// - master enable set: may master the primary bus and claim secondary cycles.
// - special cycles ignored; special cycle enable bit reads zero.
// - write-and-invalidate enable reads zero; only forwarded MWI issued.
// - palette write: I/O write, bits 9:0 at 3c6/3c8/3c9, bits 31:16 zero.
// - snoop set: claim and forward palette writes; clear: only inside I/O window.
// - parity response clear: no perr drive, no reported bit, no address-parity serr.
// - parity response set: drive perr, set reported bit only while master, allow address-parity serr.
// - reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_map.vh"
module ppc_cmd (
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // configuration access
  input wire cfg_wr_i,
  input wire cfg_rd_i,
  input wire [5:0] cfg_dword_i,
  input wire [3:0] cfg_be_n_i,
  input wire [31:0] cfg_wdata_i,
  // primary transaction under decode
  input wire [31:0] p_addr_i,
  input wire p_is_io_i,
  input wire p_is_mem_i,
  input wire p_is_write_i,
  input wire p_is_special_i,
  input wire p_in_io_window_i,
  input wire p_in_mem_window_i,
  // secondary-side request
  input wire s_is_io_i,
  input wire s_is_mem_i,
  input wire s_in_fwd_range_i,
  input wire fwd_mwi_i,
  // parity events on the primary side
  input wire data_perr_i,
  input wire addr_perr_i,
  input wire as_master_i,
  // register read data
  output reg [15:0] cfg_rdata_o,
  // decisions
  output reg claim_p_o,
  output reg vga_fwd_o,
  output reg claim_s_o,
  output reg master_ok_o,
  output reg mwi_out_o,
  // parity outputs
  output reg perr_drive_o,
  output reg perr_reported_o,
  output reg serr_addr_ok_o,
  // command bits for the rest of the bridge
  output reg [6:0] cmd_o
);
  reg [6:0] cmd_reg;
  reg [6:0] cmd_next;
  wire claim_p;
  wire vga_hit;
  wire claim_s;
  wire master_ok;
  // next values of the registered outputs
  reg [15:0] rdata_next;
  reg claim_p_next;
  reg vga_fwd_next;
  reg claim_s_next;
  reg master_ok_next;
  reg mwi_out_next;
  reg perr_drive_next;
  reg perr_reported_next;
  reg serr_addr_ok_next;
  wire wr_hit;
  wire rd_hit;
  wire perr_resp;
  // dword decode shared by the write and read paths
  function dword_hit;
    input [5:0] dw;
    begin
      dword_hit = (dw == `PPC_CMD_DWORD);
    end
  endfunction
  // a write needs lane 0, since every command bit here lives in the low byte
  assign wr_hit = cfg_wr_i && dword_hit(cfg_dword_i) && !cfg_be_n_i[0];
  assign rd_hit = cfg_rd_i && dword_hit(cfg_dword_i);
  assign perr_resp = cmd_reg[`PPC_BIT_PERR_RESP];
  // low byte lane only carries writable bits; 3, 4 and 7 masked off
  always @* begin
    cmd_next = cmd_reg;
    if (wr_hit) begin
      cmd_next = cfg_wdata_i[6:0] & `PPC_CMD_RW_MASK;
    end
  end
  // every decision formed here, registered below so outputs come from flops
  always @* begin
    rdata_next = rd_hit ? {9'h000, cmd_reg} : 16'h0000;
    claim_p_next = claim_p;
    vga_fwd_next = vga_hit && claim_p;
    claim_s_next = claim_s;
    master_ok_next = master_ok;
    mwi_out_next = fwd_mwi_i && master_ok;
    perr_drive_next = data_perr_i && perr_resp;
    perr_reported_next = data_perr_i && as_master_i && perr_resp;
    serr_addr_ok_next = addr_perr_i && perr_resp;
  end
  // registers only change by config write; software must set them first
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      cmd_reg <= `PPC_CMD_RESET;
    end else begin
      cmd_reg <= cmd_next;
    end
  end
  ppc_decode u_dec (
    .cmd_i(cmd_reg),
    .addr_i(p_addr_i),
    .is_io_i(p_is_io_i),
    .is_mem_i(p_is_mem_i),
    .is_write_i(p_is_write_i),
    .is_special_i(p_is_special_i),
    .in_io_window_i(p_in_io_window_i),
    .in_mem_window_i(p_in_mem_window_i),
    .sec_is_io_i(s_is_io_i),
    .sec_is_mem_i(s_is_mem_i),
    .sec_in_fwd_range_i(s_in_fwd_range_i),
    .claim_p_o(claim_p),
    .vga_hit_o(vga_hit),
    .claim_s_o(claim_s),
    .master_ok_o(master_ok)
  );
  // all outputs registered, so decisions lag inputs by one edge

  // upper command bits and other dwords read zero here
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg_rdata_o <= 16'h0000;
    end else begin
      cfg_rdata_o <= rdata_next;
    end
  end

  // primary claim, io and memory enables
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      claim_p_o <= 1'b0;
    end else begin
      claim_p_o <= claim_p_next;
    end
  end

  // palette forward only when the cycle is also claimed
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      vga_fwd_o <= 1'b0;
    end else begin
      vga_fwd_o <= vga_fwd_next;
    end
  end

  // secondary claim, gated by master enable
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      claim_s_o <= 1'b0;
    end else begin
      claim_s_o <= claim_s_next;
    end
  end

  // primary mastering permission
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      master_ok_o <= 1'b0;
    end else begin
      master_ok_o <= master_ok_next;
    end
  end

  // mwi only passes through from a forwarded master
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      mwi_out_o <= 1'b0;
    end else begin
      mwi_out_o <= mwi_out_next;
    end
  end

  // parity error drive, silent while response is off
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      perr_drive_o <= 1'b0;
    end else begin
      perr_drive_o <= perr_drive_next;
    end
  end

  // pulse only; the sticky status bit lives outside this block
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      perr_reported_o <= 1'b0;
    end else begin
      perr_reported_o <= perr_reported_next;
    end
  end

  // address parity may reach the system error line
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      serr_addr_ok_o <= 1'b0;
    end else begin
      serr_addr_ok_o <= serr_addr_ok_next;
    end
  end

  // copy of the command bits for the rest of the bridge
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      cmd_o <= `PPC_CMD_RESET;
    end else begin
      cmd_o <= cmd_reg;
    end
  end
endmodule // ppc_cmd
`default_nettype wire

// ---- logic/ppc_decode.v ----
// primary-side claim and master gating from the command bits
`timescale 1ns/1ps
`default_nettype none
`include "ppc_map.vh"
module ppc_decode (
  // command bits
  input wire [6:0] cmd_i,
  // primary transaction under decode
  input wire [31:0] addr_i,
  input wire is_io_i,
  input wire is_mem_i,
  input wire is_write_i,
  input wire is_special_i,
  input wire in_io_window_i,
  input wire in_mem_window_i,
  // secondary-side request
  input wire sec_is_io_i,
  input wire sec_is_mem_i,
  input wire sec_in_fwd_range_i,
  // decisions
  output wire claim_p_o,
  output wire vga_hit_o,
  output wire claim_s_o,
  output wire master_ok_o
);
  // palette write: low ten bits match, 15:10 ignored, upper half zero
  function vga_pal;
    input [31:0] a;
    begin
      vga_pal = (a[31:16] == 16'h0000) &&
                ((a[9:0] == `PPC_VGA_ADDR_A) || (a[9:0] == `PPC_VGA_ADDR_B) ||
                 (a[9:0] == `PPC_VGA_ADDR_C));
    end
  endfunction
  wire pal_wr = is_io_i && is_write_i && vga_pal(addr_i);
  // snoop decodes palette writes positively; otherwise only the window counts
  assign vga_hit_o = pal_wr && cmd_i[`PPC_BIT_VGA_SNOOP];
  // special cycles are never claimed
  assign claim_p_o = !is_special_i &&
    ((is_io_i && cmd_i[`PPC_BIT_IO_EN] && (in_io_window_i || vga_hit_o)) ||
     (is_mem_i && cmd_i[`PPC_BIT_MEM_EN] && in_mem_window_i));
  // secondary claims and primary mastering both hang on master enable
  assign claim_s_o = cmd_i[`PPC_BIT_MST_EN] && (sec_is_io_i || sec_is_mem_i) && sec_in_fwd_range_i;
  assign master_ok_o = cmd_i[`PPC_BIT_MST_EN];
endmodule // ppc_decode
`default_nettype wire

// ---- logic/ppc_map.vh ----
// register offsets, field positions and reset values of the primary command register block
`ifndef PPC_MAP_VH
`define PPC_MAP_VH
`define PPC_CMD_DWORD 6'h01
`define PPC_BIT_IO_EN 0
`define PPC_BIT_MEM_EN 1
`define PPC_BIT_MST_EN 2
`define PPC_BIT_SPC_EN 3
`define PPC_BIT_MWI_EN 4
`define PPC_BIT_VGA_SNOOP 5
`define PPC_BIT_PERR_RESP 6
`define PPC_CMD_RESET 7'h00
`define PPC_CMD_RW_MASK 7'h67
`define PPC_VGA_ADDR_A 10'h3c6
`define PPC_VGA_ADDR_B 10'h3c8
`define PPC_VGA_ADDR_C 10'h3c9
`endif

// ---- verif/ppc_cmd_assertions.sv ----
// port assertions for the primary command register
`timescale 1ns/1ps
`default_nettype none
module ppc_cmd_chk (
  // watched ports
  input wire core_clk_i, rst_i, cfg_wr_i, cfg_rd_i, fwd_mwi_i, data_perr_i, addr_perr_i, as_master_i,
  input wire [5:0] cfg_dword_i,
  input wire [3:0] cfg_be_n_i,
  input wire [31:0] cfg_wdata_i,
  input wire [15:0] cfg_rdata_o,
  input wire [6:0] cmd_o,
  input wire claim_s_o, master_ok_o, mwi_out_o, perr_drive_o, serr_addr_ok_o, perr_reported_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_rd; cfg_rd_i && cfg_dword_i == 6'h01 |=> cfg_rdata_o == {9'h000, cmd_o}; endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
  property p_wr; cfg_wr_i && cfg_dword_i == 6'h01 && !cfg_be_n_i[0] |-> ##2 cmd_o == ($past(cfg_wdata_i[6:0], 2) & 7'h67); endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_spc; cfg_rdata_o[15:7] == 9'h000 && cfg_rdata_o[4:3] == 2'h0 && cmd_o[4:3] == 2'h0; endproperty
  a_spc: assert property (p_spc) else $error("fixed bits set");
  property p_mst; master_ok_o == cmd_o[2]; endproperty
  a_mst: assert property (p_mst) else $error("master gate wrong");
  property p_cls; claim_s_o |-> cmd_o[2]; endproperty
  a_cls: assert property (p_cls) else $error("secondary claim");
  property p_perr; !$past(rst_i) |-> perr_drive_o == ($past(data_perr_i) && cmd_o[6]); endproperty
  a_perr: assert property (p_perr) else $error("perr drive wrong");
  property p_serr; !$past(rst_i) |-> serr_addr_ok_o == ($past(addr_perr_i) && cmd_o[6]); endproperty
  a_serr: assert property (p_serr) else $error("serr gate wrong");
  property p_mwi; !$past(rst_i) |-> mwi_out_o == ($past(fwd_mwi_i) && cmd_o[2]); endproperty
  a_mwi: assert property (p_mwi) else $error("mwi gate wrong");
  property p_prep; !$past(rst_i) |-> perr_reported_o == ($past(data_perr_i && as_master_i) && cmd_o[6]); endproperty
  a_prep: assert property (p_prep) else $error("reported bit wrong");
endmodule // ppc_cmd_chk
bind ppc_cmd ppc_cmd_chk u_ppc_cmd_chk (.*);
`default_nettype wire

// ---- verif/ppc_cmd_tb.sv ----
// self-checking bench for the primary command register
`timescale 1ns/1ps
`default_nettype none
module ppc_cmd_tb;
  logic core_clk_i = 0, rst_i = 1, cfg_wr_i = 0, cfg_rd_i = 0, p_is_special_i = 0, p_in_io_window_i = 0;
  logic p_in_mem_window_i = 1, s_is_io_i = 1, s_is_mem_i = 0, s_in_fwd_range_i = 1, fwd_mwi_i = 1;
  logic data_perr_i = 1, addr_perr_i = 1, as_master_i = 1, p_is_io_i, p_is_mem_i, p_is_write_i;
  logic [5:0] cfg_dword_i = 6'h01;
  logic [3:0] cfg_be_n_i = 4'h0;
  logic [31:0] cfg_wdata_i = 32'h0, p_addr_i, addr = 32'h0;
  logic [1:0] kind = 2'h0;
  logic [15:0] cfg_rdata_o;
  logic [6:0] cmd_o;
  logic claim_p_o, vga_fwd_o, claim_s_o, master_ok_o, mwi_out_o, perr_drive_o, perr_reported_o, serr_addr_ok_o;
  int miscompares = 0, tests_run = 0;
  ppc_cmd u_ppc_cmd (.*);
  ppc_pri_mst u_ppc_pri_mst (.kind_i(kind), .addr_i(addr), .p_addr_o(p_addr_i), .p_io_o(p_is_io_i),
    .p_mem_o(p_is_mem_i), .p_wr_o(p_is_write_i));
  initial forever #5 core_clk_i = ~core_clk_i;
  task chk(input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // config write, one strobe cycle
  task wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d);
    @(posedge core_clk_i);
    {cfg_wr_i, cfg_dword_i, cfg_be_n_i, cfg_wdata_i} <= {1'b1, dw, be, d};
    @(posedge core_clk_i);
    cfg_wr_i <= 0;
  endtask
  // config read, data stands one cycle after the strobe
  task rd(input logic [5:0] dw, input logic [15:0] exp);
    @(posedge core_clk_i);
    {cfg_rd_i, cfg_dword_i} <= {1'b1, dw};
    @(posedge core_clk_i);
    cfg_rd_i <= 0;
    #1 chk(exp, cfg_rdata_o);
  endtask
  // primary cycle, then claim and palette forward
  task cyc(input logic [1:0] k, input logic [31:0] a, input logic [1:0] exp);
    @(posedge core_clk_i);
    {kind, addr} <= {k, a};
    repeat (2) @(posedge core_clk_i);
    #1 chk({14'h0, exp}, {14'h0, claim_p_o, vga_fwd_o});
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_i <= 0;
    rd(6'h01, 16'h0000);
    cyc(2'h2, 32'h100, 2'h0);
    cyc(2'h1, 32'h3c6, 2'h0);
    chk(16'h0, {15'h0, perr_reported_o});
    wr(6'h01, 4'h0, 32'hff);
    rd(6'h01, 16'h0067);
    wr(6'h01, 4'h1, 32'h0);
    wr(6'h02, 4'h0, 32'h0);
    rd(6'h01, 16'h0067);
    rd(6'h02, 16'h0000);
    cyc(2'h1, 32'hfbc8, 2'h3);
    cyc(2'h1, 32'h103c9, 2'h0);
    cyc(2'h2, 32'h100, 2'h2);
    chk(16'h1, {15'h0, claim_s_o});
    wr(6'h01, 4'h0, 32'h4b);
    rd(6'h01, 16'h0043);
    cyc(2'h1, 32'h3c6, 2'h0);
    chk(16'h0, {15'h0, claim_s_o});
    chk(16'h1, {15'h0, perr_reported_o});
    p_in_io_window_i <= 1;
    cyc(2'h1, 32'h3c6, 2'h2);
    p_is_special_i <= 1;
    cyc(2'h2, 32'h100, 2'h0);
    end_sim;
  end
endmodule // ppc_cmd_tb
`default_nettype wire

// ---- verif/ppc_pri_mst.sv ----
// primary master model presenting one cycle kind
`timescale 1ns/1ps
`default_nettype none
module ppc_pri_mst (
  // kind: 0 idle, 1 io write, 2 mem read
  input wire logic [1:0] kind_i,
  input wire logic [31:0] addr_i,
  // cycle signals toward the bridge
  output logic [31:0] p_addr_o,
  output logic p_io_o, p_mem_o, p_wr_o
);
  // idle bus shows inverted address so stale values never decode
  assign p_addr_o = kind_i == 2'h0 ? ~addr_i : addr_i;
  assign p_io_o = kind_i == 2'h1;
  assign p_mem_o = kind_i == 2'h2;
  assign p_wr_o = kind_i == 2'h1;
endmodule // ppc_pri_mst
`default_nettype wire
